// ---- bench/compact_timer_checker.sv ----
// Port checker of the compact timer, bound to its top module
`timescale 1ns/1ns
module compact_timer_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Pins and requests
  input wire logic ext_clock_pin,
  input wire logic ext_trigger,
  input wire logic irq_compare_a,
  input wire logic irq_compare_p
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic seen_a;
  logic seen_p;

  // Match pulses seen since software last cleared the flags; clear wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      seen_a <= 1'b0;
      seen_p <= 1'b0;
    end else begin
      if (irq_compare_a) seen_a <= 1'b1;
      if (irq_compare_p) seen_p <= 1'b1;
      if (reg_write && reg_addr == 3'h7 && reg_wdata[1]) seen_a <= 1'b0;
      if (reg_write && reg_addr == 3'h7 && reg_wdata[0]) seen_p <= 1'b0;
    end
  end

  AST_RDATA_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read answer");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> reg_rdata == 8'h00
    && !ext_trigger && !irq_compare_a && !irq_compare_p)
    else $error("outputs active right after reset");
  AST_CTL0_UNUSED: assert property (reg_read && reg_addr == 3'h0 |=> reg_rdata[2:0] == 3'h0)
    else $error("unused control bits read nonzero");
  AST_CTL1_READBACK: assert property (reg_write && reg_addr == 3'h1 ##1 reg_read
    && reg_addr == 3'h1 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("control register readback differs");
  AST_FLAG_STICKY: assert property (reg_read && reg_addr == 3'h7 |=>
    (reg_rdata[1] || !$past(seen_a)) && (reg_rdata[0] || !$past(seen_p))
    && reg_rdata[7:2] == 6'h00)
    else $error("match flag lost before clear");
  AST_TRIG_PULSE: assert property (ext_trigger |=> !ext_trigger)
    else $error("trigger longer than one cycle");
  AST_TRIG_AFTER_EDGE: assert property ($rose(ext_clock_pin) |-> ##[1:5] ext_trigger)
    else $error("no trigger after pin rising edge");
  AST_P_SPACING: assert property (irq_compare_p |=> !irq_compare_p [*8])
    else $error("comparator P request repeats too soon");
endmodule // compact_timer_checker

bind compact_timer_module compact_timer_checker u_checker (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .ext_clock_pin(ext_clock_pin), .ext_trigger(ext_trigger),
  .irq_compare_a(irq_compare_a), .irq_compare_p(irq_compare_p)
);

// ---- bench/test_compact_timer_module.sv ----
// Self-checking testbench of the compact timer
`timescale 1ns/1ns
module test_compact_timer_module;
  logic clock;
  logic rst_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic ext_clock_pin;
  logic sub_clock_pin;
  logic timer_output_pin;
  logic ext_trigger;
  logic irq_compare_a;
  logic irq_compare_p;
  logic pin_run;
  int n_errors;
  int n_checks;

  compact_timer_module DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_clock_pin(ext_clock_pin), .sub_clock_pin(sub_clock_pin),
    .timer_output_pin(timer_output_pin), .ext_trigger(ext_trigger),
    .irq_compare_a(irq_compare_a), .irq_compare_p(irq_compare_p));
  timer_pin_source pins (.run(pin_run), .ext_clock_pin(ext_clock_pin),
    .sub_clock_pin(sub_clock_pin));

  // ****************************************
  // Compare, bus and wait helpers
  // ****************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_int(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic wait_irq(input bit use_p, output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while ((use_p ? irq_compare_p : irq_compare_a) !== 1'b1 && n < 3000);
    if (n >= 3000) chk_int(n, 0, "request wait");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic reset_and_buffer();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk8(d, 8'h00, "reset value");
    end
    wr(3'h0, 8'h07);
    rd(3'h0, d);
    chk8(d, 8'h00, "control 0 low bits");
    wr(3'h4, 8'h34);
    wr(3'h5, 8'h12);
    rd(3'h5, d);
    chk8(d, 8'h12, "a high");
    rd(3'h4, d);
    chk8(d, 8'h34, "a low");
    wr(3'h4, 8'h77);
    rd(3'h5, d);
    rd(3'h4, d);
    chk8(d, 8'h34, "a low after lone low write");
    wr(3'h3, 8'h55);
    wr(3'h2, 8'h66);
    rd(3'h3, d);
    chk8(d, 8'h00, "count high read only");
    rd(3'h2, d);
    chk8(d, 8'h00, "count low read only");
    // Write then read of control 1 with no gap between the strobes
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= 3'h1;
    reg_wdata <= 8'h5A;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk8(reg_rdata, 8'h5A, "control 1 back to back");
  endtask
  task automatic clock_sources();
    int per [8];
    int n;
    per = '{2 * compact_timer_pkg::DIV_SYS, 2, 2 * compact_timer_pkg::DIV_HIGH_A,
      2 * compact_timer_pkg::DIV_HIGH_B, 20, 20, 20, 20};
    pin_run = 1'b1;
    wr(3'h1, 8'hC1);
    wr(3'h4, 8'h01);
    wr(3'h5, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(3'h0, 8'h00);
      wr(3'h0, {1'b0, 3'(c), 1'b1, 3'b000});
      wait_irq(1'b0, n);
      wait_irq(1'b0, n);
      chk_int(n, per[c], "match period per clock");
    end
  endtask
  task automatic restart_clear();
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] v1;
    wr(3'h4, 8'hFF);
    wr(3'h5, 8'hFF);
    wr(3'h0, 8'h10);
    wr(3'h0, 8'h18);
    repeat (300) @(posedge clock);
    wr(3'h0, 8'h10);
    rd(3'h3, hi);
    rd(3'h2, lo);
    v1 = {hi, lo};
    repeat (20) @(posedge clock);
    rd(3'h3, hi);
    rd(3'h2, lo);
    chk_bit(v1 > 16'h00C8 && {hi, lo} == v1, 1'b1, "count held while off");
    wr(3'h0, 8'h18);
    rd(3'h3, hi);
    rd(3'h2, lo);
    chk_bit({hi, lo} < 16'h0008, 1'b1, "count cleared on start");
    // Pause keeps the count and does not clear it
    wr(3'h0, 8'h98);
    rd(3'h3, hi);
    rd(3'h2, lo);
    v1 = {hi, lo};
    repeat (20) @(posedge clock);
    rd(3'h3, hi);
    rd(3'h2, lo);
    chk_bit(v1 > 16'h0000 && {hi, lo} == v1, 1'b1, "count held while paused");
  endtask
  task automatic flags_and_p();
    logic [7:0] d;
    int n;
    wr(3'h0, 8'h10);
    rd(3'h7, d);
    chk8(d, 8'h02, "a flag still set");
    wr(3'h7, 8'h02);
    rd(3'h7, d);
    chk8(d, 8'h00, "a flag cleared");
    wr(3'h6, 8'h01);
    wr(3'h1, 8'hC0);
    wr(3'h0, 8'h18);
    wait_irq(1'b1, n);
    wait_irq(1'b1, n);
    chk_int(n, 256, "p match period");
    wr(3'h0, 8'h10);
    rd(3'h7, d);
    chk8(d, 8'h01, "only p flag");
  endtask
  task automatic compare_output();
    logic [3:0] tab [5];
    int n;
    tab = '{4'b0011, 4'b0110, 4'b1001, 4'b1101, 4'b1110};
    wr(3'h4, 8'h04);
    wr(3'h5, 8'h00);
    foreach (tab[i]) begin
      wr(3'h0, 8'h10);
      wr(3'h1, {2'b00, tab[i][3:2], tab[i][1], 3'b001});
      wr(3'h0, 8'h18);
      @(posedge clock);
      #1;
      chk_bit(timer_output_pin, tab[i][1], "initial level on start");
      wait_irq(1'b0, n);
      chk_bit(timer_output_pin, tab[i][0], "level after match");
      if (tab[i][3:2] == 2'b11) begin
        wait_irq(1'b0, n);
        chk_bit(timer_output_pin, ~tab[i][0], "toggle back");
      end
    end
  endtask
  task automatic pwm_output();
    logic [7:0] cfg [3];
    int exp_n [3];
    int n;
    // Plain, inverted polarity, and period and duty swapped
    cfg = '{8'hA8, 8'hAC, 8'hAA};
    exp_n = '{64, 192, 256};
    wr(3'h6, 8'h01);
    wr(3'h4, 8'h40);
    wr(3'h5, 8'h00);
    foreach (cfg[k]) begin
      wr(3'h0, 8'h10);
      wr(3'h1, cfg[k]);
      wr(3'h0, 8'h18);
      repeat (300) @(posedge clock);
      n = 0;
      repeat (256) begin
        @(posedge clock);
        #1;
        if (timer_output_pin === 1'b1) n++;
      end
      chk_int(n, exp_n[k], "active cycles per period");
    end
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watchdog
  initial begin
    #200000;
    n_errors++;
    $display("[ERR] %0t run did not finish", $time);
    conclude();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    pin_run = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    reset_and_buffer();
    clock_sources();
    restart_clear();
    flags_and_p();
    compare_output();
    pwm_output();
    conclude();
  end
endmodule // test_compact_timer_module

// ---- bench/timer_pin_source.sv ----
// Far-side model: external clock pin source and sub clock
`timescale 1ns/1ns
module timer_pin_source #(
  parameter int HALF_NS = 50
) (
  // Control
  input wire logic run,
  // Clock pins
  output logic ext_clock_pin,
  output logic sub_clock_pin
);
  // Sub clock runs free, off the system clock edges
  initial begin
    sub_clock_pin = 1'b0;
    #3;
    forever #(HALF_NS) sub_clock_pin = ~sub_clock_pin;
  end

  // Pin clock stands still while run is low; pin is an input only
  initial begin
    ext_clock_pin = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      if (run) ext_clock_pin = ~ext_clock_pin;
    end
  end
endmodule // timer_pin_source

// ---- core/compact_timer_module.sv ----
// Compact 16-bit timer: counter, comparators, output pin, registers
`timescale 1ns/1ns
module compact_timer_module (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Clock pins
  input wire logic ext_clock_pin,
  input wire logic sub_clock_pin,
  // Waveform and trigger
  output logic timer_output_pin,
  output logic ext_trigger,
  // Interrupt requests
  output logic irq_compare_a,
  output logic irq_compare_p
);

  // ****************************************
  // Declarations
  // ****************************************
  count_tick_if tick ();

  logic [7:0] timer_control_0;
  logic [7:0] timer_control_1;
  logic [15:0] count;
  logic [15:0] compare_a_value;
  logic [7:0] compare_p_value;
  logic [7:0] hold_buffer;
  logic flag_a;
  logic flag_p;
  logic on_last;
  logic out_level;
  logic pwm_out;

  logic counter_on;
  logic counter_pause;
  logic start_edge;
  logic [1:0] action;
  logic init_level;
  logic polarity;
  logic duty_swap;
  logic clear_sel;
  compact_timer_pkg::mode_e mode;
  logic running_tick;
  logic match_a;
  logic match_p;
  logic clear_now;
  logic duty_active;
  logic next_out_level;
  logic next_pwm_out;
  logic clear_flag_a;
  logic clear_flag_p;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_a_low;
  logic wr_a_high;
  logic wr_p;
  logic wr_status;
  logic rd_count_high;
  logic rd_a_high;

  // ****************************************
  // Clock source
  // ****************************************
  count_clock_select clock_select (
    .clock(clock),
    .rst_n(rst_n),
    .sub_clock_pin(sub_clock_pin),
    .ext_clock_pin(ext_clock_pin),
    .tick(tick)
  );

  // Field extraction from the control registers
  assign counter_on = timer_control_0[compact_timer_pkg::CTL0_ON_BIT];
  assign counter_pause = timer_control_0[compact_timer_pkg::CTL0_PAUSE_BIT];
  assign tick.clk_sel = timer_control_0[compact_timer_pkg::CTL0_CLK_SEL_LSB +: 3];
  assign mode = compact_timer_pkg::mode_e'(timer_control_1[compact_timer_pkg::CTL1_MODE_LSB +: 2]);
  assign action = timer_control_1[compact_timer_pkg::CTL1_ACTION_LSB +: 2];
  assign init_level = timer_control_1[compact_timer_pkg::CTL1_INIT_LEVEL_BIT];
  assign polarity = timer_control_1[compact_timer_pkg::CTL1_POLARITY_BIT];
  assign duty_swap = timer_control_1[compact_timer_pkg::CTL1_SWAP_BIT];
  assign clear_sel = timer_control_1[compact_timer_pkg::CTL1_CLEAR_SEL_BIT];

  // ****************************************
  // Register decode
  // ****************************************

  // Write strobes per register
  assign wr_ctl0 = reg_write && (reg_addr == compact_timer_pkg::REG_TIMER_CONTROL_0);
  assign wr_ctl1 = reg_write && (reg_addr == compact_timer_pkg::REG_TIMER_CONTROL_1);
  assign wr_a_low = reg_write && (reg_addr == compact_timer_pkg::REG_COMPARE_A_LOW_BYTE);
  assign wr_a_high = reg_write && (reg_addr == compact_timer_pkg::REG_COMPARE_A_HIGH_BYTE);
  assign wr_p = reg_write && (reg_addr == compact_timer_pkg::REG_COMPARE_P_VALUE);
  assign wr_status = reg_write && (reg_addr == compact_timer_pkg::REG_MATCH_STATUS);

  // Read strobes with a side effect on the holding buffer
  assign rd_count_high = reg_read && (reg_addr == compact_timer_pkg::REG_COUNT_HIGH_BYTE);
  assign rd_a_high = reg_read && (reg_addr == compact_timer_pkg::REG_COMPARE_A_HIGH_BYTE);

  // Control registers, low three bits of control 0 unimplemented
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_control_0 <= compact_timer_pkg::RESET_BYTE;
      timer_control_1 <= compact_timer_pkg::RESET_BYTE;
    end else begin
      if (wr_ctl0) begin
        timer_control_0 <= {reg_wdata[7:3], 3'h0};
      end
      if (wr_ctl1) begin
        timer_control_1 <= reg_wdata;
      end
    end
  end

  // Shared holding buffer for all low bytes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_buffer <= compact_timer_pkg::RESET_BYTE;
    end else if (wr_a_low) begin
      hold_buffer <= reg_wdata;
    end else if (rd_count_high) begin
      hold_buffer <= count[7:0];
    end else if (rd_a_high) begin
      hold_buffer <= compare_a_value[7:0];
    end
  end

  // Compare A pair: high byte write also moves buffer to low byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      compare_a_value <= compact_timer_pkg::RESET_WORD;
    end else if (wr_a_high) begin
      compare_a_value <= {reg_wdata, hold_buffer};
    end
  end

  // Compare P value, a single byte
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      compare_p_value <= compact_timer_pkg::RESET_BYTE;
    end else if (wr_p) begin
      compare_p_value <= reg_wdata;
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= compact_timer_pkg::RESET_BYTE;
    end else if (reg_read) begin
      unique case (reg_addr)
        compact_timer_pkg::REG_TIMER_CONTROL_0: reg_rdata <= timer_control_0;
        compact_timer_pkg::REG_TIMER_CONTROL_1: reg_rdata <= timer_control_1;
        compact_timer_pkg::REG_COUNT_LOW_BYTE: reg_rdata <= hold_buffer;
        compact_timer_pkg::REG_COUNT_HIGH_BYTE: reg_rdata <= count[15:8];
        compact_timer_pkg::REG_COMPARE_A_LOW_BYTE: reg_rdata <= hold_buffer;
        compact_timer_pkg::REG_COMPARE_A_HIGH_BYTE: reg_rdata <= compare_a_value[15:8];
        compact_timer_pkg::REG_COMPARE_P_VALUE: reg_rdata <= compare_p_value;
        compact_timer_pkg::REG_MATCH_STATUS: reg_rdata <= {6'h00, flag_a, flag_p};
      endcase
    end else begin
      reg_rdata <= compact_timer_pkg::RESET_BYTE;
    end
  end

  // ****************************************
  // Counter and comparators
  // ****************************************

  // Counter-on history for the start edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      on_last <= 1'b0;
    end else begin
      on_last <= counter_on;
    end
  end

  assign start_edge = counter_on & ~on_last;

  // Count enable when switched on and not paused
  assign running_tick = tick.count_tick & counter_on & ~counter_pause & ~start_edge;

  // Comparator A on the full count, P on the top byte
  assign match_a = running_tick && (count == compare_a_value);
  // P match at the last count of its top-byte window; zero means overflow
  assign match_p = running_tick && (count[7:0] == 8'hFF)
    && ((count[15:8] + 8'h01) == compare_p_value);

  // Clear source: PWM follows the period comparator
  always_comb begin
    unique case (mode)
      compact_timer_pkg::MODE_PWM: clear_now = duty_swap ? match_a : match_p;
      default: clear_now = clear_sel ? match_a : match_p;
    endcase
  end

  // The 16-bit up-counter; software only clears it on start
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= compact_timer_pkg::RESET_WORD;
    end else if (start_edge) begin
      count <= compact_timer_pkg::RESET_WORD;
    end else if (clear_now) begin
      count <= compact_timer_pkg::RESET_WORD;
    end else if (running_tick) begin
      count <= count + 16'h0001;
    end
  end

  // ****************************************
  // Match flags and interrupt requests
  // ****************************************

  // Write one to clear, a new match wins over the clear
  assign clear_flag_a = wr_status && reg_wdata[compact_timer_pkg::STATUS_FLAG_A_BIT];
  assign clear_flag_p = wr_status && reg_wdata[compact_timer_pkg::STATUS_FLAG_P_BIT];

  // Sticky flags for polling software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_a <= 1'b0;
      flag_p <= 1'b0;
    end else begin
      flag_a <= match_a | (flag_a & ~clear_flag_a);
      flag_p <= match_p | (flag_p & ~clear_flag_p);
    end
  end

  // Request pulses, registered one cycle after the match
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_compare_a <= 1'b0;
      irq_compare_p <= 1'b0;
    end else begin
      irq_compare_a <= match_a;
      irq_compare_p <= match_p;
    end
  end

  // Trigger pulse from the synchronised pin edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ext_trigger <= 1'b0;
    end else begin
      ext_trigger <= tick.pin_edge;
    end
  end

  // ****************************************
  // Output waveform
  // ****************************************

  // Compare mode level: start restores the initial level
  always_comb begin
    next_out_level = out_level;
    if (start_edge) begin
      next_out_level = init_level;
    end else if (match_a && (mode == compact_timer_pkg::MODE_COMPARE)) begin
      unique case (action)
        compact_timer_pkg::ACT_NONE: next_out_level = out_level;
        compact_timer_pkg::ACT_LOW: next_out_level = 1'b0;
        compact_timer_pkg::ACT_HIGH: next_out_level = 1'b1;
        compact_timer_pkg::ACT_TOGGLE: next_out_level = ~out_level;
      endcase
    end
  end

  // Duty comparison against the duty comparator
  assign duty_active = duty_swap ? (count[15:8] < compare_p_value) : (count < compare_a_value);

  // PWM level with the active level from the initial-level bit
  always_comb begin
    unique case (action)
      compact_timer_pkg::PWM_INACTIVE: next_pwm_out = ~init_level;
      compact_timer_pkg::PWM_ACTIVE: next_pwm_out = init_level;
      compact_timer_pkg::PWM_WAVE: next_pwm_out = duty_active ? init_level : ~init_level;
      default: next_pwm_out = ~init_level;
    endcase
  end

  // Output state registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_level <= 1'b0;
      pwm_out <= 1'b0;
    end else begin
      out_level <= next_out_level;
      pwm_out <= counter_on ? next_pwm_out : ~init_level;
    end
  end

  // Pin drive per mode, polarity applies in compare and PWM modes only
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      timer_output_pin <= 1'b0;
    end else begin
      unique case (mode)
        compact_timer_pkg::MODE_COMPARE: timer_output_pin <= next_out_level ^ polarity;
        compact_timer_pkg::MODE_PWM: timer_output_pin <= pwm_out ^ polarity;
        compact_timer_pkg::MODE_TIMER: timer_output_pin <= 1'b0;
        default: timer_output_pin <= 1'b0;
      endcase
    end
  end

endmodule // compact_timer_module

// ---- core/count_clock_select.sv ----
// Counter clock source selector: prescaler, sub clock and pin edges
`timescale 1ns/1ns
module count_clock_select (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Asynchronous clock sources
  input wire logic sub_clock_pin,
  input wire logic ext_clock_pin,
  // Tick carrier
  count_tick_if.source tick
);

  logic [5:0] prescale;
  logic [1:0] pin_sync;
  logic [1:0] sub_sync;
  logic pin_last;
  logic sub_last;
  logic pin_rise;
  logic pin_fall;
  logic sub_rise;

  // Free running prescaler for the divided internal clocks
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prescale <= 6'h00;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  // Two-stage synchronisers, then a history stage for edges
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_sync <= 2'h0;
      sub_sync <= 2'h0;
      pin_last <= 1'b0;
      sub_last <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], ext_clock_pin};
      sub_sync <= {sub_sync[0], sub_clock_pin};
      pin_last <= pin_sync[1];
      sub_last <= sub_sync[1];
    end
  end

  // Edge pulses from the synchronised levels
  assign pin_rise = pin_sync[1] & ~pin_last;
  assign pin_fall = ~pin_sync[1] & pin_last;
  assign sub_rise = sub_sync[1] & ~sub_last;

  // Pin rising edge also offered as a trigger pulse
  assign tick.pin_edge = pin_rise;

  // One-cycle count enable from the selected source
  always_comb begin
    unique case (tick.clk_sel)
      compact_timer_pkg::CLK_SYS_DIV4:
        tick.count_tick = (prescale[1:0] == 2'(compact_timer_pkg::DIV_SYS - 1));
      compact_timer_pkg::CLK_SYS: tick.count_tick = 1'b1;
      compact_timer_pkg::CLK_HIGH_DIV16:
        tick.count_tick = (prescale[3:0] == 4'(compact_timer_pkg::DIV_HIGH_A - 1));
      compact_timer_pkg::CLK_HIGH_DIV64:
        tick.count_tick = (prescale == 6'(compact_timer_pkg::DIV_HIGH_B - 1));
      compact_timer_pkg::CLK_SUB_A, compact_timer_pkg::CLK_SUB_B: tick.count_tick = sub_rise;
      compact_timer_pkg::CLK_PIN_RISE: tick.count_tick = pin_rise;
      compact_timer_pkg::CLK_PIN_FALL: tick.count_tick = pin_fall;
    endcase
  end

endmodule // count_clock_select

// ---- include/compact_timer_pkg.sv ----
// Constants, field layout and mode codes of the compact timer
//
// Functional notes
// - Separate interrupt requests for comparator A and P
// - Compare match clears counter and changes output
// - External pin clocks counter, rising or falling edge
// - Pin also triggers single pulse in other variants
// - Match output drives high, low or toggles
// - Output pin carries the PWM waveform
// - Low bytes reached through shared 8-bit buffer
// - Write low byte first, high byte copies buffer
// - Read high byte first, captures low byte
// - Core is a 16-bit up-counter
// - P compares top byte, A compares all
// - Counter cleared by counter-on rising edge and by selected match
// - Clears on overflow or selected compare match
// - Three modes: compare, timer, PWM output
// - Count pair, compare A pair, compare P, controls
// - Mode codes 00 compare, 10 PWM, 11 timer
// - Clock select codes, 110 rising, 111 falling
// - Output action 00 none, 01 low, 10 high, 11 toggle
// - Clear select chooses A match or P/overflow
package compact_timer_pkg;

  // ****************************************
  // Register indexes on the byte port
  // ****************************************
  localparam logic [2:0] REG_TIMER_CONTROL_0 = 3'h0;
  localparam logic [2:0] REG_TIMER_CONTROL_1 = 3'h1;
  localparam logic [2:0] REG_COUNT_LOW_BYTE = 3'h2;
  localparam logic [2:0] REG_COUNT_HIGH_BYTE = 3'h3;
  localparam logic [2:0] REG_COMPARE_A_LOW_BYTE = 3'h4;
  localparam logic [2:0] REG_COMPARE_A_HIGH_BYTE = 3'h5;
  localparam logic [2:0] REG_COMPARE_P_VALUE = 3'h6;
  localparam logic [2:0] REG_MATCH_STATUS = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL0_PAUSE_BIT = 7;
  localparam int CTL0_CLK_SEL_LSB = 4;
  localparam int CTL0_ON_BIT = 3;
  localparam int CTL1_MODE_LSB = 6;
  localparam int CTL1_ACTION_LSB = 4;
  localparam int CTL1_INIT_LEVEL_BIT = 3;
  localparam int CTL1_POLARITY_BIT = 2;
  localparam int CTL1_SWAP_BIT = 1;
  localparam int CTL1_CLEAR_SEL_BIT = 0;
  localparam int STATUS_FLAG_P_BIT = 0;
  localparam int STATUS_FLAG_A_BIT = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ****************************************
  // Clock selection codes and divider counts
  // ****************************************
  localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] CLK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] CLK_SUB_A = 3'h4;
  localparam logic [2:0] CLK_SUB_B = 3'h5;
  localparam logic [2:0] CLK_PIN_RISE = 3'h6;
  localparam logic [2:0] CLK_PIN_FALL = 3'h7;
  localparam int DIV_SYS = 4;
  localparam int DIV_HIGH_A = 16;
  localparam int DIV_HIGH_B = 64;

  // ****************************************
  // Operating modes and output actions
  // ****************************************
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_UNDEFINED = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } mode_e;

  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE = 2'h1;
  localparam logic [1:0] PWM_WAVE = 2'h2;

endpackage

// ---- include/count_tick_if.sv ----
// Carrier between the clock source selector and the timer core
`timescale 1ns/1ns
interface count_tick_if;
  logic [2:0] clk_sel;
  logic count_tick;
  logic pin_edge;

  modport source (input clk_sel, output count_tick, output pin_edge);
  modport sink (output clk_sel, input count_tick, input pin_edge);
endinterface
